// ### hdl/adss_sequencer.sv
// Autoranging dual-slope measurement sequencer
`timescale 1ns/100ps

module adss_sequencer #(
    parameter int NSEG         = 16,
    parameter int LINE_TICKS   = adss_pkg::LINE_TICKS,
    parameter int R4_INT_TICKS = adss_pkg::R4_INT_TICKS,
    parameter int MEAS_TICKS   = adss_pkg::MEAS_TICKS,
    parameter int OVL_COUNT    = adss_pkg::OVL_COUNT
) (
    input  wire logic                      MCLK,
    input  wire logic                      RST,
    input  wire logic                      CMP_IN,
    input  wire logic [NSEG-1:0]           SEG_FIRST,
    input  wire logic [NSEG-1:0]           SEG_SECOND,
    output logic                           OFFSET_CANCEL_PHASE,
    output logic                           INTEG_CONNECT,
    output logic                           POS_SEL_A,
    output logic                           NEG_SEL_B,
    output logic [1:0]                     RANGE,
    output logic                           UNDERRANGE,
    output logic                           OVERLOAD,
    output logic [adss_pkg::CNT_W-1:0]     DISP_COUNT,
    output logic [1:0]                     DISP_RANGE,
    output logic                           OVERLOAD_GLYPH,
    output logic                           DISP_UPDATE,
    output logic                           BACKPLANE1,
    output logic                           BACKPLANE2,
    output logic [NSEG-1:0]                SEG_DRV
);

    localparam int CW = adss_pkg::CNT_W;
    localparam int PW = adss_pkg::PH_W;
    localparam int MW = adss_pkg::MEAS_W;

    // ------------------------------------------------------------
    // Internal clock tick
    // ------------------------------------------------------------
    logic div_r;
    logic tick;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_r <= 1'b0;
        end else begin
            div_r <= ~div_r;
        end
    end

    // all phase counts advance once per two input clocks
    assign tick = div_r;

    // ------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------
    adss_pkg::adss_state_type state_r;
    adss_pkg::adss_state_type state_nxt;
    logic [PW-1:0]  ph_cnt_r;
    logic [PW-1:0]  ph_cnt_nxt;
    logic [MW-1:0]  meas_cnt_r;
    logic [CW-1:0]  dcnt_r;
    logic [CW-1:0]  dcnt_nxt;
    logic [1:0]     range_r;
    logic [1:0]     range_nxt;
    logic           first_r;
    logic           first_nxt;
    logic           pol_r;
    logic           pol_nxt;
    logic           under_r;
    logic           under_nxt;
    logic           ovl_r;
    logic           ovl_nxt;
    logic           latch_now;
    logic           latch_ovl;

    // ------------------------------------------------------------
    // Phase lengths and decode
    // ------------------------------------------------------------
    wire [PW-1:0] az_len   = first_r ? PW'(LINE_TICKS)
                                     : PW'(LINE_TICKS - adss_pkg::R2_AZ_SHORTFALL);
    wire [PW-1:0] int_len  = (range_r == adss_pkg::RANGE_4) ? PW'(R4_INT_TICKS)
                                                            : PW'(LINE_TICKS);
    wire          az_done  = (ph_cnt_r == az_len - PW'(1));
    wire          int_done = (ph_cnt_r == int_len - PW'(1));
    wire          meas_end = (meas_cnt_r >= MW'(MEAS_TICKS - 1));
    wire          crossed  = (CMP_IN != pol_r);
    wire          at_ovl   = (dcnt_r == CW'(OVL_COUNT - 1));
    wire          below    = (dcnt_r < CW'(adss_pkg::UNDER_COUNT));
    wire          last_rng = (range_r == adss_pkg::RANGE_4);

    // range 1 gate, one tick in every 100
    wire gate_r1 = (ph_cnt_r % PW'(adss_pkg::R1_GATE_GAP)) == PW'(0);
    // range 2 gate, one tick in every 10
    wire gate_r2 = (ph_cnt_r % PW'(adss_pkg::R2_GATE_GAP)) == PW'(0);
    // ranges 3 and 4 integrate on every tick
    wire int_gate = (range_r == 2'h0) ? gate_r1 :
                    (range_r == 2'h1) ? gate_r2 : 1'b1;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        ph_cnt_nxt = ph_cnt_r;
        dcnt_nxt   = dcnt_r;
        range_nxt  = range_r;
        first_nxt  = first_r;
        pol_nxt    = pol_r;
        under_nxt  = under_r;
        ovl_nxt    = ovl_r;
        latch_now  = 1'b0;
        latch_ovl  = 1'b0;
        if (tick) begin
            unique case (state_r)
                adss_pkg::ST_AZ: begin
                    ph_cnt_nxt = ph_cnt_r + PW'(1);
                    if (az_done) begin
                        state_nxt  = adss_pkg::ST_INT;
                        ph_cnt_nxt = '0;
                    end
                end
                adss_pkg::ST_INT: begin
                    ph_cnt_nxt = ph_cnt_r + PW'(1);
                    // range 4 window is 10000 ticks
                    if (int_done) begin
                        state_nxt  = adss_pkg::ST_DSAMP;
                        ph_cnt_nxt = '0;
                    end
                end
                adss_pkg::ST_DSAMP: begin
                    pol_nxt   = CMP_IN;
                    dcnt_nxt  = '0;
                    state_nxt = adss_pkg::ST_POS_SEL_A;
                end
                adss_pkg::ST_POS_SEL_A: begin
                    dcnt_nxt = dcnt_r + CW'(1);
                    // stop on comparator change; step range if below underrange and not range 4, else latch
                    if (crossed) begin
                        dcnt_nxt = dcnt_r;
                        if (below && !last_rng) begin
                            under_nxt = 1'b1;
                            range_nxt = range_r + 2'h1;
                            first_nxt = 1'b0;
                            state_nxt = adss_pkg::ST_AZ;
                        end else begin
                            latch_now = 1'b1;
                            state_nxt = adss_pkg::ST_FINAL;
                        end
                    // no crossing by 4000 is overload
                    end else if (at_ovl) begin
                        ovl_nxt   = 1'b1;
                        latch_now = 1'b1;
                        latch_ovl = 1'b1;
                        state_nxt = adss_pkg::ST_FINAL;
                    end
                end
                adss_pkg::ST_FINAL: begin
                    if (meas_end) begin
                        state_nxt  = adss_pkg::ST_AZ;
                        range_nxt  = adss_pkg::RANGE_1;
                        first_nxt  = 1'b1;
                        ph_cnt_nxt = '0;
                        under_nxt  = 1'b0;
                        ovl_nxt    = 1'b0;
                    end
                end
                default: begin
                    state_nxt = adss_pkg::ST_AZ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    // reset starts the initial offset cancel
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_r <= adss_pkg::ST_AZ;
            ph_cnt_r <= '0;
            dcnt_r <= '0;
            range_r <= adss_pkg::RANGE_1;
            first_r <= 1'b1;
            pol_r <= 1'b0;
            under_r <= 1'b0;
            ovl_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ph_cnt_r <= ph_cnt_nxt;
            dcnt_r <= dcnt_nxt;
            range_r <= range_nxt;
            first_r <= first_nxt;
            pol_r <= pol_nxt;
            under_r <= under_nxt;
            ovl_r <= ovl_nxt;
        end
    end

    // Measurement period counter; restarts with the range search
    wire meas_restart = tick && (state_r == adss_pkg::ST_FINAL) && meas_end;

    always_ff @(posedge MCLK) begin
        if (RST || meas_restart) begin
            meas_cnt_r <= '0;
        end else if (tick) begin
            meas_cnt_r <= meas_cnt_r + MW'(1);
        end
    end

    // ------------------------------------------------------------
    // Display latches
    // ------------------------------------------------------------
    logic [CW-1:0] disp_cnt_r;
    logic [1:0]    disp_rng_r;
    logic          glyph_r;
    logic          upd_r;

    // copy result into the output latches
    always_ff @(posedge MCLK) begin
        if (RST) begin
            disp_cnt_r <= '0;
            disp_rng_r <= adss_pkg::RANGE_1;
            glyph_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            upd_r <= latch_now;
            if (latch_now) begin
                disp_cnt_r <= dcnt_r;
                disp_rng_r <= range_r;
                glyph_r <= latch_ovl;
            end
        end
    end

    // ------------------------------------------------------------
    // Duplex segment drive
    // ------------------------------------------------------------
    logic [PW-1:0]   bp_cnt_r;
    logic            bp_sel_r;
    logic [NSEG-1:0] seg_r;
    wire             bp_flip = tick && (bp_cnt_r == PW'(adss_pkg::BP_HALF_TICKS - 1));

    always_ff @(posedge MCLK) begin
        if (RST) begin
            bp_cnt_r <= '0;
            bp_sel_r <= 1'b0;
        end else if (bp_flip) begin
            bp_cnt_r <= '0;
            bp_sel_r <= ~bp_sel_r;
        end else if (tick) begin
            bp_cnt_r <= bp_cnt_r + PW'(1);
        end
    end

    // first segment on backplane 1, second on backplane 2
    always_ff @(posedge MCLK) begin
        if (RST) begin
            seg_r <= '0;
        end else begin
            seg_r <= bp_sel_r ? SEG_SECOND : SEG_FIRST;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // buffers tied to common during offset cancel
    assign OFFSET_CANCEL_PHASE = (state_r == adss_pkg::ST_AZ)
                              || (state_r == adss_pkg::ST_FINAL);
    // integrate node connected only on gated ticks
    assign INTEG_CONNECT = (state_r == adss_pkg::ST_INT) && int_gate;
    assign POS_SEL_A = (state_r == adss_pkg::ST_POS_SEL_A) && pol_r;
    assign NEG_SEL_B = (state_r == adss_pkg::ST_POS_SEL_A) && !pol_r;

    assign RANGE          = range_r;
    assign UNDERRANGE     = under_r;
    assign OVERLOAD       = ovl_r;
    assign DISP_COUNT     = disp_cnt_r;
    assign DISP_RANGE     = disp_rng_r;
    // overload pattern held in display latch
    assign OVERLOAD_GLYPH = glyph_r;
    assign DISP_UPDATE    = upd_r;
    assign BACKPLANE1     = ~bp_sel_r;
    assign BACKPLANE2     = bp_sel_r;
    assign SEG_DRV        = seg_r;

endmodule

// ### hdl/adss_pkg.sv
// Constants shared by the autoranging dual-slope sequencer
package adss_pkg;

    // ------------------------------------------------------------
    // Timing counts, in internal (divided) clock ticks
    // ------------------------------------------------------------
    localparam int LINE_TICKS      = 1000;   // One line cycle
    localparam int OSC_PER_LINE    = 2000;   // Oscillator cycles per line cycle
    localparam int R2_AZ_SHORTFALL = 360;    // Range 2..4 cycle is shorter by this
    localparam int R4_INT_TICKS    = 10000;  // Range 4 integration, ten line cycles
    localparam int MEAS_TICKS      = 24000;  // Fixed measurement period
    localparam int OVL_COUNT       = 4000;   // Deintegration overload limit
    localparam int UNDER_COUNT     = 360;    // Underrange threshold
    localparam int R1_GATE_GAP     = 100;    // Range 1: one tick in 100 -> 10 ticks
    localparam int R2_GATE_GAP     = 10;     // Range 2: one tick in 10 -> 100 ticks
    localparam int BP_HALF_TICKS   = 400;    // Backplane half period

    // ------------------------------------------------------------
    // Widths and ranges
    // ------------------------------------------------------------
    localparam int CNT_W  = 12;
    localparam int PH_W   = 14;
    localparam int MEAS_W = 15;
    localparam logic [1:0] RANGE_1 = 2'h0;
    localparam logic [1:0] RANGE_4 = 2'h3;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_AZ    = 3'h0,
        ST_INT   = 3'h1,
        ST_DSAMP = 3'h2,
        ST_POS_SEL_A = 3'h3,
        ST_FINAL = 3'h4
    } adss_state_type;

endpackage

// ### tb/adss_properties.sv
// Port assertions for the dual-slope sequencer
`timescale 1ns/100ps
module adss_properties #(
    parameter int NSEG      = 16,
    parameter int OVL_COUNT = adss_pkg::OVL_COUNT
) (
    input wire logic                      MCLK,
    input wire logic                      RST,
    input wire logic                      CMP_IN,
    input wire logic [NSEG-1:0]           SEG_FIRST,
    input wire logic [NSEG-1:0]           SEG_SECOND,
    input wire logic                      OFFSET_CANCEL_PHASE,
    input wire logic                      INTEG_CONNECT,
    input wire logic                      POS_SEL_A,
    input wire logic                      NEG_SEL_B,
    input wire logic [1:0]                RANGE,
    input wire logic                      UNDERRANGE,
    input wire logic                      OVERLOAD,
    input wire logic [adss_pkg::CNT_W-1:0] DISP_COUNT,
    input wire logic [1:0]                DISP_RANGE,
    input wire logic                      OVERLOAD_GLYPH,
    input wire logic                      DISP_UPDATE,
    input wire logic                      BACKPLANE1,
    input wire logic                      BACKPLANE2,
    input wire logic [NSEG-1:0]           SEG_DRV
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // ------
    // Deintegrate run length
    // ------
    wire         desel = POS_SEL_A | NEG_SEL_B;
    logic [15:0] dcnt_r;
    always_ff @(posedge MCLK) begin
        dcnt_r <= (RST | ~desel) ? 16'h0000 : dcnt_r + 16'h0001;
    end
    sequence s_pos_sel_a_end;
        desel ##1 !desel;
    endsequence
    chk_sel_onehot: assert property (!(POS_SEL_A && NEG_SEL_B))
        else $error("both discharge selects high");
    chk_az_quiet: assert property (OFFSET_CANCEL_PHASE |-> !desel && !INTEG_CONNECT)
        else $error("switches active in offset cancel");
    chk_bp_compl: assert property (BACKPLANE1 != BACKPLANE2)
        else $error("backplanes not complementary");
    chk_seg_pick: assert property (!$past(RST) |-> SEG_DRV ==
        ($past(BACKPLANE1) ? $past(SEG_FIRST) : $past(SEG_SECOND))) else $error("segment mux");
    chk_disp_valid: assert property (DISP_UPDATE && !OVERLOAD && DISP_RANGE !=
        adss_pkg::RANGE_4 |-> DISP_COUNT >= adss_pkg::UNDER_COUNT) else $error("low count shown");
    chk_range_step: assert property ($changed(RANGE) |->
        RANGE == $past(RANGE) + 2'h1 || RANGE == adss_pkg::RANGE_1) else $error("range skip");
    chk_under_held: assert property (RANGE != 2'h0 && $stable(RANGE) |-> UNDERRANGE)
        else $error("range stepped without underrange");
    chk_ovl_limit: assert property (dcnt_r <= 2 * OVL_COUNT + 4)
        else $error("deintegrate ran past overload");
    chk_pos_sel_a_next: assert property (s_pos_sel_a_end |-> ##[0:4] OFFSET_CANCEL_PHASE)
        else $error("no offset cancel after deintegrate");
    chk_ovl_glyph: assert property ($rose(OVERLOAD) |-> ##[0:1] OVERLOAD_GLYPH)
        else $error("overload glyph missing");
endmodule

bind adss_sequencer adss_properties #(.NSEG(NSEG), .OVL_COUNT(OVL_COUNT)) adss_properties_inst (
    .MCLK(MCLK), .RST(RST), .CMP_IN(CMP_IN), .SEG_FIRST(SEG_FIRST), .SEG_SECOND(SEG_SECOND),
    .OFFSET_CANCEL_PHASE(OFFSET_CANCEL_PHASE), .INTEG_CONNECT(INTEG_CONNECT),
    .POS_SEL_A(POS_SEL_A), .NEG_SEL_B(NEG_SEL_B), .RANGE(RANGE), .UNDERRANGE(UNDERRANGE),
    .OVERLOAD(OVERLOAD), .DISP_COUNT(DISP_COUNT), .DISP_RANGE(DISP_RANGE),
    .OVERLOAD_GLYPH(OVERLOAD_GLYPH), .DISP_UPDATE(DISP_UPDATE), .BACKPLANE1(BACKPLANE1),
    .BACKPLANE2(BACKPLANE2), .SEG_DRV(SEG_DRV));

// ### tb/adss_analog_model.sv
// Behavioural integrator and comparator on the far side
`timescale 1ns/100ps
module adss_analog_model #(
    parameter int DSTEP = 4
) (
    input  wire logic               mclk,
    input  wire logic               offset_cancel,
    input  wire logic               connect,
    input  wire logic               dis_pos,
    input  wire logic               dis_neg,
    input  wire logic signed [31:0] vin,
    output logic                    cmp_out
);
    // ------
    // Integrator charge
    // ------
    int acc_r;
    // A wrong select drives charge away from zero, as the real part would
    always_ff @(posedge mclk) begin
        if (offset_cancel) begin
            acc_r <= 0;
        end else if (connect) begin
            acc_r <= acc_r + vin;
        end else if (dis_pos) begin
            acc_r <= acc_r - DSTEP;
        end else if (dis_neg) begin
            acc_r <= acc_r + DSTEP;
        end
    end
    assign cmp_out = (acc_r > 0);
endmodule

// ### tb/test_adss_sequencer.sv
// Self-checking bench for the dual-slope sequencer
`timescale 1ns/100ps
module test_adss_sequencer;
    localparam int LT = 400;
    localparam int MT = 5000;
    typedef struct {
        int         vin;
        logic [1:0] rng;
        int         cnt;
        logic       ovl;
    } adss_row_type;
    // Range 1 row follows range 4 so a search that resumed would show
    adss_row_type rows [6] = '{'{1, 2'h3, 200, 1'b0}, '{400, 2'h0, 400, 1'b0},
        '{40, 2'h1, 400, 1'b0}, '{-400, 2'h0, 400, 1'b0}, '{600, 2'h0, 0, 1'b1},
        '{4, 2'h2, 400, 1'b0}};
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    int          vin = 1;
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    int          k;
    logic        cmp, oc, ic, ps, ns, ur, ovl, upd, bp1, bp2, glyph;
    logic [1:0]  rng, drng;
    logic [11:0] dcnt;
    logic [15:0] segd;

    adss_sequencer #(.LINE_TICKS(LT), .R4_INT_TICKS(800), .MEAS_TICKS(MT), .OVL_COUNT(500))
    adss_sequencer_inst (.MCLK(MCLK), .RST(RST), .CMP_IN(cmp), .SEG_FIRST(16'hA5A5),
        .SEG_SECOND(16'h5A5A), .OFFSET_CANCEL_PHASE(oc), .INTEG_CONNECT(ic), .POS_SEL_A(ps),
        .NEG_SEL_B(ns), .RANGE(rng), .UNDERRANGE(ur), .OVERLOAD(ovl), .DISP_COUNT(dcnt),
        .DISP_RANGE(drng), .OVERLOAD_GLYPH(glyph), .DISP_UPDATE(upd), .BACKPLANE1(bp1),
        .BACKPLANE2(bp2), .SEG_DRV(segd));
    adss_analog_model adss_analog_model_inst (.mclk(MCLK), .offset_cancel(oc), .connect(ic),
        .dis_pos(ps), .dis_neg(ns), .vin(vin), .cmp_out(cmp));

    // ------
    // Shared tasks
    // ------
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Sticky overload from an older reading must not count as a new result
    task automatic wait_evt;
        logic prev;
        prev = 1'b1;
        n = 0;
        while (n < 25000) begin
            @(posedge MCLK);
            #1;
            n++;
            if (upd === 1'b1 || (ovl === 1'b1 && prev !== 1'b1)) break;
            prev = ovl;
        end
        chk(n < 25000, "no result");
    endtask

    always #2 MCLK = ~MCLK;
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 100000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        foreach (rows[i]) begin
            @(posedge MCLK);
            vin <= rows[i].vin;
            wait_evt();
            @(posedge MCLK);
            #1;
            chk(ovl === rows[i].ovl, "overload flag");
            chk(glyph === rows[i].ovl, "overload glyph");
            if (rows[i].ovl === 1'b0) begin
                chk(drng === rows[i].rng, "display range");
                chk(dcnt >= rows[i].cnt - 3 && dcnt <= rows[i].cnt + 3, "display count");
                chk(ur === (rows[i].rng != 2'h0), "underrange");
            end
            repeat (8) @(posedge MCLK);
        end
        wait_evt();
        wait_evt();
        chk(n == 2 * MT, "measurement period");
        @(posedge MCLK);
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        #1;
        chk(oc === 1'b1 && rng === 2'h0 && dcnt === 12'h000 && ovl === 1'b0 && ur === 1'b0
            && bp1 === 1'b1 && bp2 === 1'b0 && segd === 16'h0000, "reset state");
        @(posedge MCLK);
        RST <= 1'b0;
        n = 0;
        while (n < 5000) begin
            @(posedge MCLK);
            #1;
            n++;
            if (oc !== 1'b1) break;
        end
        chk(n >= 2 * LT - 3 && n <= 2 * LT + 3, "first offset cancel length");
        n = 0;
        k = 0;
        while (ps !== 1'b1 && ns !== 1'b1 && k < 5000) begin
            n += (ic === 1'b1);
            @(posedge MCLK);
            #1;
            k++;
        end
        chk(n == 2 * (LT / 100), "range 1 gated ticks");
        // Segment word follows the backplane phase seen before the edge
        k = bp1;
        @(posedge MCLK);
        #1;
        chk(segd === (k == 1 ? 16'hA5A5 : 16'h5A5A) && bp2 === ~bp1, "segment drive");
        summarize();
    end
endmodule
